/* src/cfg_loader_defines.svh */
// Constants for the configuration mode loader: codes, counts and timing
`ifndef CFG_LOADER_DEFINES_SVH
`define CFG_LOADER_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define CONFIG_CLOCK_SLOW_HZ 1000000
`define CONFIG_CLOCK_FAST_HZ 8000000
`define CONFIG_CLOCK_SLOW_HALF ((1000000000 / `CONFIG_CLOCK_SLOW_HZ) / (2 * `CLK_PERIOD_NS))
`define CONFIG_CLOCK_FAST_HALF ((1000000000 / `CONFIG_CLOCK_FAST_HZ) / (2 * `CLK_PERIOD_NS))
`define CONFIG_CLOCK_DIV_W 6
`define PROM_ACCESS_NS 100
`define PROM_WAIT ((`PROM_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_CODE_MASTER_SERIAL 3'h0
`define MODE_CODE_SLAVE_SERIAL 3'h7
`define MODE_CODE_PAR_UP 3'h4
`define MODE_CODE_PAR_DOWN 3'h6
`define MODE_CODE_PERIPH_SYNC 3'h3
`define MODE_CODE_PERIPH_ASYNC 3'h5
`define ADDR_W 22
`define ADDR_LOW_W 18
`define ADDR_ASCEND_START 22'h000000
`define ADDR_DESCEND_START 22'h3FFFFF
`define PREAMBLE 4'h2
`define LEN_COUNT_W 24
`define BYTE_W 8
`define BUF_DEPTH 2
`endif

/* src/cfg_loader_pkg.sv */
// Types shared by the configuration mode loader
package cfg_loader_pkg;
  typedef enum logic [2:0] {
    MODE_MASTER_SERIAL, MODE_SLAVE_SERIAL, MODE_PAR_UP, MODE_PAR_DOWN,
    MODE_PERIPH_SYNC, MODE_PERIPH_ASYNC, MODE_RESERVED
  } mode_type;
  typedef enum logic [1:0] {HDR_HUNT, HDR_LENGTH, HDR_FRAMES} hdr_state_type;
  typedef enum logic {FETCH_IDLE, FETCH_WAIT} fetch_state_type;
endpackage : cfg_loader_pkg

/* src/byte_stream_if.sv */
// Byte stream with valid and ready between loader and its buffer
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [`BYTE_W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : byte_stream_if

/* src/byte_buffer.sv */
// Two-entry byte buffer, flip-flop storage addressed by index
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"
module byte_buffer (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_flush,
  byte_stream_if.sink fill,
  byte_stream_if.source drain
);
  logic [`BYTE_W-1:0] mem_q [`BUF_DEPTH];
  logic wr_idx_q;
  logic rd_idx_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign fill.ready = (count_q != 2'(`BUF_DEPTH));
  assign drain.valid = (count_q != 2'h0);
  assign drain.data = mem_q[rd_idx_q];
  assign push = fill.valid & fill.ready;
  assign pop = drain.valid & drain.ready;

  // Storage write
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else if (i_ce && push) begin
      mem_q[wr_idx_q] <= fill.data;
    end
  end

  // Pointers and count; flush drops any stale bytes between loads
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_idx_q <= 1'b0;
      rd_idx_q <= 1'b0;
      count_q <= 2'h0;
    end else if (i_ce) begin
      if (i_flush) begin
        wr_idx_q <= 1'b0;
        rd_idx_q <= 1'b0;
        count_q <= 2'h0;
      end else begin
        if (push) wr_idx_q <= ~wr_idx_q;
        if (pop) rd_idx_q <= ~rd_idx_q;
        count_q <= count_q + 2'(push) - 2'(pop);
      end
    end
  end
endmodule : byte_buffer

/* src/config_mode_loader.sv */
// Configuration loader front end: mode select, clocking, fetch, serialize, chain
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"
module config_mode_loader
  import cfg_loader_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_config_done,
  input wire logic i_own_loaded,
  input wire logic i_fast_clock,
  input wire logic i_addr22,
  input wire logic i_low_voltage,
  input wire logic i_mode_sel_hi,
  input wire logic i_mode_sel_mid,
  input wire logic i_mode_sel_lo,
  input wire logic i_config_clock,
  input wire logic i_din,
  input wire logic [`BYTE_W-1:0] i_prom_data,
  input wire logic [`BYTE_W-1:0] i_host_data,
  input wire logic i_host_wr_n,
  input wire logic i_aux_use,
  input wire logic i_aux_mid_value,
  output logic o_config_clock,
  output logic o_config_clock_oe_n,
  output logic [`ADDR_LOW_W-1:0] o_prom_addr,
  output logic o_prom_addr_oe_n,
  output logic [3:0] o_upper_prom_address,
  output logic o_upper_prom_address_oe_n,
  output logic o_host_ready,
  output logic o_dout,
  output logic o_stream_bit,
  output logic o_stream_valid,
  output logic [`LEN_COUNT_W-1:0] o_length_count,
  output logic o_length_valid,
  output mode_type o_mode,
  output logic o_loading,
  output logic o_aux_in_hi,
  output logic o_aux_in_lo,
  output logic o_mode_sel_mid,
  output logic o_mode_sel_mid_oe_n
);
  localparam int SYNC_W = 22;

  function automatic mode_type decode_mode(input logic [2:0] code);
    unique case (code)
      `MODE_CODE_MASTER_SERIAL: decode_mode = MODE_MASTER_SERIAL;
      `MODE_CODE_SLAVE_SERIAL: decode_mode = MODE_SLAVE_SERIAL;
      `MODE_CODE_PAR_UP: decode_mode = MODE_PAR_UP;
      `MODE_CODE_PAR_DOWN: decode_mode = MODE_PAR_DOWN;
      `MODE_CODE_PERIPH_SYNC: decode_mode = MODE_PERIPH_SYNC;
      `MODE_CODE_PERIPH_ASYNC: decode_mode = MODE_PERIPH_ASYNC;
      default: decode_mode = MODE_RESERVED;
    endcase
  endfunction : decode_mode

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic config_clock_prev_q;
  logic wr_n_prev_q;
  logic loading_q;
  logic configured_q;
  logic low_voltage_q;
  mode_type mode_q;
  logic par_mode;
  logic periph_mode;
  logic byte_mode;
  logic ext_clock;
  logic gen_run;
  logic [`CONFIG_CLOCK_DIV_W-1:0] div_q;
  logic [`CONFIG_CLOCK_DIV_W-1:0] half;
  logic gen_config_clock_q;
  logic gen_hit;
  logic fast_q;
  logic rise;
  logic fall;
  logic [`BYTE_W-1:0] ser_q;
  logic [3:0] ser_cnt_q;
  logic bit_valid;
  logic bit_val;
  fetch_state_type fetch_q;
  logic [3:0] wait_q;
  logic [`ADDR_W-1:0] addr_q;
  logic upper_en;
  logic host_push;
  logic fetch_push;
  hdr_state_type hdr_q;
  logic [2:0] pre_q;
  logic [4:0] len_cnt_q;
  logic fwd_q;
  logic [2:0] aux_q;
  byte_stream_if fill_if ();
  byte_stream_if drain_if ();

  // Two-stage synchronisers on the mode, clock, data-in, write strobe and both byte buses; only stage two feeds logic
  assign pin_raw = {i_mode_sel_hi, i_mode_sel_mid, i_mode_sel_lo, i_config_clock, i_din,
                    i_host_wr_n, i_prom_data, i_host_data};
  generate
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else if (i_ce) begin
          meta_q[i] <= pin_raw[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  // Mode class decode
  assign par_mode = (mode_q == MODE_PAR_UP) || (mode_q == MODE_PAR_DOWN);
  assign periph_mode = (mode_q == MODE_PERIPH_SYNC) || (mode_q == MODE_PERIPH_ASYNC);
  assign byte_mode = par_mode || periph_mode;
  assign ext_clock = (mode_q == MODE_SLAVE_SERIAL) || (mode_q == MODE_PERIPH_SYNC);

  // Load start samples mode pins and the variant strap; reserved codes stay idle
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      loading_q <= 1'b0;
      configured_q <= 1'b0;
      low_voltage_q <= 1'b0;
      mode_q <= MODE_SLAVE_SERIAL;
    end else if (i_ce) begin
      if (i_start && !loading_q) begin
        mode_q <= decode_mode(sync_q[21:19]);
        loading_q <= (decode_mode(sync_q[21:19]) != MODE_RESERVED);
        configured_q <= 1'b0;
        low_voltage_q <= i_low_voltage;
      end else if (loading_q && i_config_done) begin
        loading_q <= 1'b0;
        configured_q <= 1'b1;
      end
    end
  end

  // Generated clock runs freely in master serial, in bursts while a byte is shifting
  assign gen_run = loading_q && ((mode_q == MODE_MASTER_SERIAL) ||
                   ((par_mode || mode_q == MODE_PERIPH_ASYNC) && ser_cnt_q != 4'h0));
  assign half = fast_q ? `CONFIG_CLOCK_DIV_W'(`CONFIG_CLOCK_FAST_HALF) : `CONFIG_CLOCK_DIV_W'(`CONFIG_CLOCK_SLOW_HALF);
  assign gen_hit = (div_q == half - `CONFIG_CLOCK_DIV_W'(1));

  // Divider; a running high phase always completes so no runt pulse leaves the pin
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_q <= 6'h00;
      gen_config_clock_q <= 1'b0;
    end else if (i_ce) begin
      if (gen_run || gen_config_clock_q) begin
        div_q <= gen_hit ? 6'h00 : div_q + 6'h01;
        if (gen_hit) gen_config_clock_q <= ~gen_config_clock_q;
      end else begin
        div_q <= 6'h00;
      end
    end
  end

  // Rate starts slow and may go fast once frames begin
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fast_q <= 1'b0;
    end else if (i_ce) begin
      fast_q <= loading_q && (hdr_q == HDR_FRAMES) && i_fast_clock;
    end
  end

  // Edge events from either the own divider or the sampled external clock
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      config_clock_prev_q <= 1'b0;
      wr_n_prev_q <= 1'b1;
    end else if (i_ce) begin
      config_clock_prev_q <= sync_q[18];
      wr_n_prev_q <= sync_q[16];
    end
  end
  assign rise = ext_clock ? (sync_q[18] && !config_clock_prev_q)
                          : ((gen_run || gen_config_clock_q) && gen_hit && !gen_config_clock_q);
  assign fall = ext_clock ? (!sync_q[18] && config_clock_prev_q)
                          : ((gen_run || gen_config_clock_q) && gen_hit && gen_config_clock_q);

  // Byte source: host strobe in peripheral modes, memory fetch in parallel modes
  assign o_host_ready = loading_q && periph_mode && fill_if.ready;
  assign host_push = o_host_ready && wr_n_prev_q && !sync_q[16];
  assign fetch_push = loading_q && par_mode && (fetch_q == FETCH_WAIT) &&
                      (wait_q == 4'(`PROM_WAIT - 1));
  assign fill_if.valid = host_push || fetch_push;
  assign fill_if.data = par_mode ? sync_q[15:8] : sync_q[7:0];

  byte_buffer u_buffer (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_flush(i_start && !loading_q),
    .fill(fill_if.sink),
    .drain(drain_if.source)
  );

  // Fetch sequencer waits out the memory access, then pushes and steps the address
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fetch_q <= FETCH_IDLE;
      wait_q <= 4'h0;
      addr_q <= `ADDR_ASCEND_START;
    end else if (i_ce) begin
      if (i_start && !loading_q) begin
        fetch_q <= FETCH_IDLE;
        addr_q <= (decode_mode(sync_q[21:19]) == MODE_PAR_DOWN) ? `ADDR_DESCEND_START
                                                                : `ADDR_ASCEND_START;
      end else begin
        unique case (fetch_q)
          FETCH_IDLE: begin
            wait_q <= 4'h0;
            if (loading_q && par_mode && fill_if.ready) fetch_q <= FETCH_WAIT;
          end
          FETCH_WAIT: begin
            if (fetch_push) begin
              fetch_q <= FETCH_IDLE;
              // One counter for all 22 bits keeps upper and lower lines continuous
              addr_q <= (mode_q == MODE_PAR_DOWN) ? addr_q - 22'h000001
                                                  : addr_q + 22'h000001;
            end else begin
              wait_q <= wait_q + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // Address pins; upper lines only once 22 lines are selected or on low-voltage parts
  assign upper_en = loading_q && par_mode && (low_voltage_q || i_addr22);
  assign o_prom_addr = addr_q[`ADDR_LOW_W-1:0];
  assign o_upper_prom_address = addr_q[`ADDR_W-1:`ADDR_LOW_W];
  assign o_prom_addr_oe_n = !(loading_q && par_mode);
  assign o_upper_prom_address_oe_n = !upper_en;
  assign o_config_clock = gen_config_clock_q;
  assign o_config_clock_oe_n = !(loading_q && !ext_clock);

  // Serializer: byte in when empty, D0 first, one bit per rising edge
  assign drain_if.ready = loading_q && byte_mode && (ser_cnt_q == 4'h0);
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ser_q <= 8'h00;
      ser_cnt_q <= 4'h0;
    end else if (i_ce) begin
      if (!loading_q) begin
        ser_cnt_q <= 4'h0;
      end else if (drain_if.valid && drain_if.ready) begin
        ser_q <= drain_if.data;
        ser_cnt_q <= 4'(`BYTE_W);
      end else if (rise && ser_cnt_q != 4'h0) begin
        ser_q <= {1'b0, ser_q[`BYTE_W-1:1]};
        ser_cnt_q <= ser_cnt_q - 4'h1;
      end
    end
  end

  // Bit stream: serial modes sample input on the rising edge, byte modes shift out
  assign bit_valid = loading_q && rise && (byte_mode ? (ser_cnt_q != 4'h0) : 1'b1);
  assign bit_val = byte_mode ? ser_q[0] : sync_q[17];
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_stream_bit <= 1'b0;
      o_stream_valid <= 1'b0;
    end else if (i_ce) begin
      o_stream_valid <= bit_valid;
      if (bit_valid) o_stream_bit <= bit_val;
    end
  end

  // Header tracker: hunt preamble, then shift in the length count MSB first
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hdr_q <= HDR_HUNT;
      pre_q <= 3'h0;
      len_cnt_q <= 5'h00;
      o_length_count <= 24'h000000;
      o_length_valid <= 1'b0;
    end else if (i_ce) begin
      o_length_valid <= 1'b0;
      if (!loading_q) begin
        hdr_q <= HDR_HUNT;
        pre_q <= 3'h0;
      end else if (bit_valid) begin
        pre_q <= {pre_q[1:0], bit_val};
        unique case (hdr_q)
          HDR_HUNT: begin
            len_cnt_q <= 5'h00;
            if ({pre_q, bit_val} == `PREAMBLE) hdr_q <= HDR_LENGTH;
          end
          HDR_LENGTH: begin
            o_length_count <= {o_length_count[`LEN_COUNT_W-2:0], bit_val};
            len_cnt_q <= len_cnt_q + 5'h01;
            if (len_cnt_q == 5'(`LEN_COUNT_W - 1)) begin
              hdr_q <= HDR_FRAMES;
              o_length_valid <= 1'b1;
            end
          end
          HDR_FRAMES: begin
            hdr_q <= HDR_FRAMES;
          end
        endcase
      end
    end
  end

  // Chain output: bit caught at rise, launched at the following fall
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fwd_q <= 1'b1;
      o_dout <= 1'b1;
    end else if (i_ce) begin
      if (bit_valid) fwd_q <= bit_val;
      if (!loading_q) begin
        o_dout <= 1'b1;
      end else if (fall) begin
        o_dout <= (hdr_q == HDR_FRAMES && !i_own_loaded) ? 1'b1 : fwd_q;
      end
    end
  end

  // Mode pins as user pins after load, only when the design asks for them
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aux_q <= 3'h0;
    end else if (i_ce) begin
      aux_q <= {sync_q[21], sync_q[19], i_aux_mid_value} & {3{configured_q && i_aux_use}};
    end
  end
  assign o_aux_in_hi = aux_q[2];
  assign o_aux_in_lo = aux_q[1];
  assign o_mode_sel_mid = aux_q[0];
  assign o_mode_sel_mid_oe_n = !(configured_q && i_aux_use);
  assign o_mode = mode_q;
  assign o_loading = loading_q;
endmodule : config_mode_loader

/* testbench/config_mode_loader_checker.sv */
// Port assertions for the configuration mode loader
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"
module config_mode_loader_checker
  import cfg_loader_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic o_config_clock,
  input wire logic o_config_clock_oe_n,
  input wire logic [`ADDR_LOW_W-1:0] o_prom_addr,
  input wire logic o_prom_addr_oe_n,
  input wire logic [3:0] o_upper_prom_address,
  input wire logic o_upper_prom_address_oe_n,
  input wire logic o_host_ready,
  input wire logic o_stream_valid,
  input wire logic o_length_valid,
  input wire mode_type o_mode,
  input wire logic o_loading,
  input wire logic o_mode_sel_mid_oe_n
);
  logic [`ADDR_W-1:0] addr;
  logic is_par;
  logic last_q;
  logic armed_q;
  logic [5:0] gap_q;
  assign addr = {o_upper_prom_address, o_prom_addr};
  assign is_par = o_mode inside {MODE_PAR_UP, MODE_PAR_DOWN};
  // Cycles since the generated clock last moved; frozen cycles are not counted
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      last_q <= 1'b0;
      armed_q <= 1'b0;
      gap_q <= 6'h00;
    end else if (i_ce) begin
      last_q <= o_config_clock;
      armed_q <= o_loading && (armed_q || o_config_clock != last_q);
      gap_q <= (o_config_clock != last_q) ? 6'h00 : gap_q + 6'h01;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  reserved_idle_a: assert property (o_mode == MODE_RESERVED |-> !o_loading)
    else $error("load running on a reserved code");
  start_mode_a: assert property ($rose(o_loading) |-> o_mode != MODE_RESERVED)
    else $error("load started without a valid mode");
  clock_drive_a: assert property ($rose(o_loading) && (is_par || o_mode inside
    {MODE_MASTER_SERIAL, MODE_PERIPH_ASYNC}) |-> !o_config_clock_oe_n)
    else $error("generated clock not driven");
  clock_input_a: assert property (o_mode inside {MODE_SLAVE_SERIAL, MODE_PERIPH_SYNC}
    |-> o_config_clock_oe_n) else $error("clock driven in an input mode");
  start_addr_a: assert property ($rose(o_loading) && is_par |-> !o_prom_addr_oe_n &&
    addr == (o_mode == MODE_PAR_DOWN ? `ADDR_DESCEND_START : `ADDR_ASCEND_START))
    else $error("wrong first fetch address");
  addr_step_a: assert property (o_loading && $past(o_loading) && is_par &&
    addr != $past(addr) |-> addr == (o_mode == MODE_PAR_UP ? $past(addr) + 22'h000001 :
    $past(addr) - 22'h000001)) else $error("address step not one");
  upper_hold_a: assert property ($fell(o_upper_prom_address_oe_n) |-> o_loading && is_par)
    else $error("upper address driven outside parallel load");
  ready_mode_a: assert property (o_host_ready |-> o_loading &&
    o_mode inside {MODE_PERIPH_SYNC, MODE_PERIPH_ASYNC}) else $error("ready outside host modes");
  slow_rate_a: assert property (o_loading && armed_q && o_config_clock != last_q &&
    o_mode == MODE_MASTER_SERIAL |-> gap_q == 6'h31 || gap_q == 6'h05)
    else $error("generated clock phase length wrong");
  length_pulse_a: assert property (o_length_valid |=> !o_length_valid)
    else $error("length pulse too long");
  bit_pulse_a: assert property (o_stream_valid |=> !o_stream_valid)
    else $error("bit pulse too long");
  aux_after_a: assert property ($fell(o_mode_sel_mid_oe_n) |-> !o_loading)
    else $error("middle pin driven during load");
  cover property ($rose(o_loading) && o_mode == MODE_PAR_DOWN);
  cover property (o_length_valid);
  cover property ($fell(o_host_ready) && o_loading);
endmodule : config_mode_loader_checker
bind config_mode_loader config_mode_loader_checker config_mode_loader_checker_i (
  .i_sys_clk, .i_rstn, .i_ce, .o_config_clock, .o_config_clock_oe_n, .o_prom_addr,
  .o_prom_addr_oe_n, .o_upper_prom_address, .o_upper_prom_address_oe_n, .o_host_ready,
  .o_stream_valid, .o_length_valid, .o_mode, .o_loading, .o_mode_sel_mid_oe_n);

/* testbench/prom_model.sv */
// Behavioural byte-wide memory answering the loader's fetches
`timescale 1ns/1ps
module prom_model (
  input wire logic [17:0] i_addr,
  input wire logic i_oe_n,
  output logic [7:0] o_data
);
  logic [7:0] last_q = 8'h00;
  // One byte per address; a released bus shows the inverse, never a stale match
  assign #20 o_data = i_oe_n ? ~last_q : (i_addr[7:0] ^ 8'h5A);
  always @(o_data) begin
    if (!i_oe_n) last_q = o_data;
  end
endmodule : prom_model

/* testbench/test_config_mode_loader.sv */
// Self-checking bench for the configuration mode loader
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"
module test_config_mode_loader;
  import cfg_loader_pkg::*;
  logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_start = 1'b0, i_config_done = 1'b0;
  logic i_own_loaded = 1'b0, i_fast_clock = 1'b0, i_addr22 = 1'b0, i_low_voltage = 1'b0;
  logic i_mode_sel_hi = 1'b1, i_mode_sel_mid = 1'b1, i_mode_sel_lo = 1'b1;
  // No test-access pin exists here, so nothing can toggle one while loading
  logic i_config_clock = 1'b0, i_din = 1'b1, i_host_wr_n = 1'b1;
  logic i_aux_use = 1'b0, i_aux_mid_value = 1'b0;
  logic [7:0] i_prom_data, i_host_data = 8'h00, sh = 8'h00;
  logic o_config_clock, o_config_clock_oe_n, o_prom_addr_oe_n, o_upper_prom_address_oe_n;
  logic o_host_ready, o_dout, o_stream_bit, o_stream_valid, o_length_valid, o_loading;
  logic o_aux_in_hi, o_aux_in_lo, o_mode_sel_mid, o_mode_sel_mid_oe_n;
  logic [17:0] o_prom_addr;
  logic [3:0] o_upper_prom_address;
  logic [23:0] o_length_count;
  mode_type o_mode;
  int num_errors = 0, checked = 0, bits = 0;
  config_mode_loader config_mode_loader_i (.i_sys_clk, .i_rstn, .i_ce, .i_start,
    .i_config_done, .i_own_loaded, .i_fast_clock, .i_addr22, .i_low_voltage, .i_mode_sel_hi,
    .i_mode_sel_mid, .i_mode_sel_lo, .i_config_clock, .i_din, .i_prom_data, .i_host_data,
    .i_host_wr_n, .i_aux_use, .i_aux_mid_value, .o_config_clock, .o_config_clock_oe_n,
    .o_prom_addr, .o_prom_addr_oe_n, .o_upper_prom_address, .o_upper_prom_address_oe_n,
    .o_host_ready, .o_dout, .o_stream_bit, .o_stream_valid, .o_length_count, .o_length_valid,
    .o_mode, .o_loading, .o_aux_in_hi, .o_aux_in_lo, .o_mode_sel_mid, .o_mode_sel_mid_oe_n);
  prom_model prom_model_i (.i_addr(o_prom_addr), .i_oe_n(o_prom_addr_oe_n), .o_data(i_prom_data));
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Gathers serialized bits; the first bit of a byte ends in the low position
  always @(posedge i_sys_clk) begin
    if (o_stream_valid === 1'b1) begin
      sh <= {o_stream_bit, sh[7:1]};
      bits <= bits + 1;
    end
  end
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_val(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : cmp_val
  task automatic tick(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : tick
  // Pins settle past the two-stage synchronizer before the start request
  task automatic load(input logic [2:0] c);
    {i_mode_sel_hi, i_mode_sel_mid, i_mode_sel_lo} = c;
    bits = 0;
    tick(4);
    i_start = 1'b1;
    tick(1);
    i_start = 1'b0;
    tick(1);
  endtask : load
  task automatic end_load;
    i_config_done = 1'b1;
    tick(1);
    i_config_done = 1'b0;
    tick(2);
  endtask : end_load
  // One link clock period of 125 ns; clock and data shared as a chain would wire them
  task automatic send_bit(input logic b);
    #2 i_din = b;
    #31 i_config_clock = 1'b1;
    #63 i_config_clock = 1'b0;
    #29;
  endtask : send_bit
  task automatic wait_bits(input int n);
    for (int i = 0; i < 4000 && bits < n; i++) tick(1);
  endtask : wait_bits
  function automatic mode_type exp_mode(input logic [2:0] c);
    case (c)
      3'h0: return MODE_MASTER_SERIAL;
      3'h7: return MODE_SLAVE_SERIAL;
      3'h4: return MODE_PAR_UP;
      3'h6: return MODE_PAR_DOWN;
      3'h3: return MODE_PERIPH_SYNC;
      3'h5: return MODE_PERIPH_ASYNC;
      default: return MODE_RESERVED;
    endcase
  endfunction : exp_mode
  task automatic t_modes;
    for (int c = 0; c < 8; c++) begin
      load(c[2:0]);
      cmp_val("mode", {21'h0, exp_mode(c[2:0])}, {21'h0, o_mode});
      cmp_bit("loading", exp_mode(c[2:0]) != MODE_RESERVED, o_loading);
      end_load();
    end
    i_aux_use = 1'b1;
    i_aux_mid_value = 1'b1;
    tick(4);
    cmp_bit("mid_oe_n", 1'b0, o_mode_sel_mid_oe_n);
    cmp_bit("mid_out", 1'b1, o_mode_sel_mid);
    cmp_bit("aux_hi", 1'b1, o_aux_in_hi);
    i_aux_use = 1'b0;
    tick(4);
    cmp_bit("mid_oe_n", 1'b1, o_mode_sel_mid_oe_n);
    $display("test modes done");
  endtask : t_modes
  task automatic t_master_serial;
    logic c;
    int b;
    load(3'h0);
    tick(300);
    cmp_bit("config_clock_oe_n", 1'b0, o_config_clock_oe_n);
    cmp_bit("slow_bits", bits inside {[2:4]}, 1'b1);
    // Clock enable low must freeze the generated clock and the bit stream
    i_ce = 1'b0;
    c = o_config_clock;
    b = bits;
    tick(120);
    cmp_bit("ce_hold_clk", c, o_config_clock);
    cmp_val("ce_hold_bits", b, bits);
    i_ce = 1'b1;
    end_load();
    $display("test master serial done");
  endtask : t_master_serial
  task automatic t_par(input logic [2:0] c, input logic a22, input logic lv);
    logic [21:0] a0;
    i_addr22 = a22;
    i_low_voltage = lv;
    load(c);
    a0 = (c == 3'h6) ? 22'h3FFFFF : 22'h000000;
    cmp_val("addr", a0, {o_upper_prom_address, o_prom_addr});
    cmp_bit("addr_oe_n", 1'b0, o_prom_addr_oe_n);
    cmp_bit("upper_oe_n", !(a22 || lv), o_upper_prom_address_oe_n);
    for (int i = 0; i < 40 && {o_upper_prom_address, o_prom_addr} === a0; i++) tick(1);
    cmp_val("addr_step", (c == 3'h6) ? a0 - 22'h1 : a0 + 22'h1,
      {o_upper_prom_address, o_prom_addr});
    wait_bits(8);
    cmp_val("byte", a0[7:0] ^ 8'h5A, sh);
    end_load();
    $display("test parallel done");
  endtask : t_par
  task automatic host_write(input logic [7:0] b, input logic hold);
    for (int i = 0; hold && i < 4000 && o_host_ready !== 1'b1; i++) tick(1);
    i_host_data = b;
    tick(2);
    i_host_wr_n = 1'b0;
    tick(6);
    i_host_wr_n = 1'b1;
    tick(6);
  endtask : host_write
  task automatic t_periph(input logic [2:0] c);
    logic [7:0] data [3] = '{8'hA5, 8'h3C, 8'h0F};
    load(c);
    cmp_bit("config_clock_oe_n", c == 3'h3, o_config_clock_oe_n);
    cmp_bit("ready", 1'b1, o_host_ready);
    for (int k = 0; k < 3; k++) host_write(data[k], 1'b1);
    cmp_bit("full", 1'b0, o_host_ready);
    host_write(8'hFF, 1'b0);
    for (int j = 0; j < 3; j++) begin
      if (c == 3'h3) repeat (8) send_bit(1'b0);
      wait_bits(8 * (j + 1));
      cmp_val("byte", data[j], sh);
      if (j == 0) cmp_bit("ready", 1'b1, o_host_ready);
    end
    if (c == 3'h3) repeat (8) send_bit(1'b0);
    tick(1000);
    cmp_val("bits", 24, bits);
    end_load();
    $display("test peripheral done");
  endtask : t_periph
  task automatic t_slave;
    logic [23:0] len;
    logic [3:0] pre;
    len = 24'h000123;
    pre = `PREAMBLE;
    load(3'h7);
    cmp_bit("config_clock_oe_n", 1'b1, o_config_clock_oe_n);
    repeat (8) send_bit(1'b1);
    for (int i = 3; i >= 0; i--) send_bit(pre[i]);
    for (int i = 23; i >= 0; i--) send_bit(len[i]);
    tick(5);
    cmp_val("length", len, o_length_count);
    cmp_val("bits", 36, bits);
    send_bit(1'b0);
    tick(5);
    cmp_bit("dout_hold", 1'b1, o_dout);
    i_own_loaded = 1'b1;
    send_bit(1'b0);
    tick(5);
    cmp_bit("dout_pass", 1'b0, o_dout);
    end_load();
    $display("test slave serial done");
  endtask : t_slave
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  initial begin
    tick(10);
    cmp_bit("rst_dout", 1'b1, o_dout);
    cmp_bit("rst_loading", 1'b0, o_loading);
    cmp_bit("rst_ready", 1'b0, o_host_ready);
    cmp_bit("rst_clk_oe_n", 1'b1, o_config_clock_oe_n);
    i_rstn = 1'b1;
    tick(2);
    t_modes();
    t_master_serial();
    t_par(3'h6, 1'b0, 1'b0);
    t_par(3'h6, 1'b1, 1'b0);
    t_par(3'h4, 1'b0, 1'b1);
    t_periph(3'h5);
    t_periph(3'h3);
    t_slave();
    finish_test();
  end
  // Whole run is about 8k cycles; this limit cuts a hang short
  initial begin
    #500000;
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : test_config_mode_loader
